/* hdl/cbt_ack_dec.v */
`timescale 1ns/1ns
`default_nettype none
`include "cbt_defs.vh"

module cbt_ack_dec
(
    // acknowledge pins, active low
    input wire [1:0] data_size_ack_n,
    input wire autovector_n,
    // decoded result
    output reg ack_rec,
    output reg [1:0] ack_width
);

    // ----------------------------------------
    // dynamic bus sizing decode
    // ----------------------------------------
    // pair to width
    always @*
    begin
        ack_rec = 1'b1;
        ack_width = `CBT_W32;
        if (!autovector_n)
            ack_width = `CBT_W32;
        else if (data_size_ack_n == 2'h0)
            ack_width = `CBT_W32;
        else if (data_size_ack_n == 2'h1)
            ack_width = `CBT_W16;
        else if (data_size_ack_n == 2'h2)
            ack_width = `CBT_W8;
        else
        begin
            ack_rec = 1'b0;
            ack_width = `CBT_WNONE;
        end
    end

endmodule // cbt_ack_dec
`default_nettype wire

/* hdl/cbt_bus_ctrl.v */
`timescale 1ns/1ns
`default_nettype none
`include "cbt_defs.vh"

module cbt_bus_ctrl
#(
    parameter FIFO_DEPTH = `CBT_FIFO_DEPTH
)
(
    // clock and reset
    input wire clk,
    input wire rst_n,
    // request side
    input wire req_valid,
    output reg req_ready,
    input wire [`CBT_ADDR_W-1:0] req_addr,
    input wire [`CBT_SPACE_W-1:0] req_space,
    input wire [1:0] req_size,
    input wire req_write,
    input wire [`CBT_DATA_W-1:0] req_wdata,
    input wire req_first,
    input wire req_ci_out,
    input wire req_burst,
    input wire req_table,
    input wire req_cache_en,
    input wire req_cancel,
    // completion side
    output wire done_valid,
    input wire done_ready,
    output wire [`CBT_DATA_W-1:0] done_data,
    output wire [1:0] done_width,
    output wire done_ci,
    output wire done_err,
    output wire done_last,
    // bus outputs
    output reg [`CBT_ADDR_W-1:0] address,
    output reg [`CBT_SPACE_W-1:0] space_code,
    output reg read_not_write,
    output reg [1:0] transfer_bytes,
    output reg cache_inhibit_out_n,
    output reg ext_cycle_start_n,
    output reg operand_cycle_start_n,
    output reg address_strobe_n,
    output reg data_strobe_n,
    output reg data_buffer_en_n,
    output reg cache_burst_req_n,
    output reg [`CBT_DATA_W-1:0] data_out,
    output reg data_oe,
    // bus inputs
    input wire [`CBT_DATA_W-1:0] data_in,
    input wire [1:0] data_size_ack_n,
    input wire sync_terminate_n,
    input wire bus_error_n,
    input wire halt_n,
    input wire autovector_n,
    input wire cache_inhibit_in_n,
    input wire cache_burst_ack_n
);

    // ----------------------------------------
    // bus states, one clk per half bus clock
    // ----------------------------------------
    localparam ST_IDLE = 4'h0;
    localparam ST_S0 = 4'h1;
    localparam ST_S1 = 4'h2;
    localparam ST_S2 = 4'h3;
    localparam ST_W1 = 4'h4;
    localparam ST_S3 = 4'h5;
    localparam ST_S4 = 4'h6;
    localparam ST_S5 = 4'h7;
    localparam ST_T2 = 4'h8;
    localparam ST_B1 = 4'h9;
    localparam ST_END = 4'hA;
    localparam ST_HALT = 4'hB;
    localparam integer BEATS = `CBT_BURST_BEATS;
    localparam [1:0] LAST_BEAT = BEATS[1:0] - 2'h1;

    reg [3:0] state;
    // ph high: current state ends on a rising bus clock edge
    reg ph;
    reg r_first;
    reg r_ci_out;
    reg r_write;
    reg r_burst;
    reg r_table;
    reg r_cache_en;
    reg [1:0] r_size;
    reg [1:0] r_off;
    reg ack_seen;
    reg bus_error_seen;
    reg halt_seen;
    reg retry_pend;
    reg ci_lat;
    reg cb_lat;
    reg [1:0] width_lat;
    reg [1:0] beat;

    wire ack_rec;
    wire [1:0] ack_width;
    wire fifo_in_ready;
    wire [2:0] fifo_level;
    wire [`CBT_ENT_W-1:0] fifo_out;
    wire take;
    wire launch;
    wire burst_ok;
    wire ci_eff;
    wire bus_error_now;
    wire retry_now;
    wire push;
    wire room_next;
    wire beat_last;
    reg [`CBT_ENT_W-1:0] entry;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function [2:0] cbt_nbytes;
        input [1:0] sz;
        begin
            case (sz)
                `CBT_TB_LONG: cbt_nbytes = 3'h4;
                `CBT_TB_BYTE: cbt_nbytes = 3'h1;
                `CBT_TB_WORD: cbt_nbytes = 3'h2;
                default: cbt_nbytes = 3'h3;
            endcase
        end
    endfunction

    // right-justify the requested bytes from the active lanes
    function [31:0] cbt_align;
        input [31:0] d;
        input [1:0] w;
        input [1:0] off;
        input [1:0] sz;
        reg [2:0] nb;
        reg [2:0] avail;
        reg [2:0] n;
        reg [2:0] sh;
        begin
            nb = cbt_nbytes(sz);
            avail = 3'h4 - {1'b0, off};
            n = (nb < avail) ? nb : avail;
            sh = avail - n;
            if (w == `CBT_W8)
                cbt_align = {24'h000000, d[31:24]};
            else if (w == `CBT_W16)
                cbt_align = {16'h0000, d[31:16]};
            else
                cbt_align = (d >> {sh, 3'h0}) & ~(32'hFFFFFFFF << {n, 3'h0});
        end
    endfunction

    cbt_ack_dec u_ack
    (
        .data_size_ack_n(data_size_ack_n),
        .autovector_n(autovector_n),
        .ack_rec(ack_rec),
        .ack_width(ack_width)
    );

    cbt_fifo #(.WIDTH(`CBT_ENT_W), .DEPTH(FIFO_DEPTH), .AW(2)) u_fifo
    (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(entry),
        .out_valid(done_valid),
        .out_ready(done_ready),
        .out_data(fifo_out),
        .level(fifo_level)
    );

    assign done_data = fifo_out[`CBT_ENT_DATA_MSB:`CBT_ENT_DATA_LSB];
    assign done_width = fifo_out[`CBT_ENT_WID_MSB:`CBT_ENT_WID_LSB];
    assign done_ci = fifo_out[`CBT_ENT_CI];
    assign done_err = fifo_out[`CBT_ENT_ERR];
    assign done_last = fifo_out[`CBT_ENT_LAST];

    assign take = req_valid && req_ready;
    assign launch = take || (state == ST_HALT && halt_n && ph);
    // a burst needs room for every beat, else fall back to one entry
    assign burst_ok = req_burst && !req_write && (fifo_level == 3'h0);
    assign ci_eff = !cache_inhibit_in_n && r_cache_en && !r_ci_out && !r_write && !r_table;
    assign bus_error_now = bus_error_seen || !bus_error_n;
    assign retry_now = bus_error_now && (halt_seen || !halt_n);
    assign beat_last = !(cb_lat && beat != LAST_BEAT && !bus_error_seen);
    assign push = (state == ST_S4 && !retry_now) || (state == ST_T2 && !(bus_error_seen && halt_seen));
    assign room_next = push ? (fifo_level < FIFO_DEPTH - 1) : fifo_in_ready;

    // ----------------------------------------
    // completion entry
    // ----------------------------------------
    always @*
    begin
        entry = {`CBT_ENT_W{1'b0}};
        if (state == ST_S4)
        begin
            if (!r_write && ack_seen)
                entry[`CBT_ENT_DATA_MSB:`CBT_ENT_DATA_LSB] = cbt_align(data_in, width_lat, r_off, r_size);
            entry[`CBT_ENT_WID_MSB:`CBT_ENT_WID_LSB] = width_lat;
            entry[`CBT_ENT_CI] = ci_lat;
            entry[`CBT_ENT_ERR] = bus_error_now;
            entry[`CBT_ENT_LAST] = 1'b1;
        end
        else
        begin
            if (!r_write)
                entry[`CBT_ENT_DATA_MSB:`CBT_ENT_DATA_LSB] = cbt_align(data_in, `CBT_W32, r_off, r_size);
            entry[`CBT_ENT_WID_MSB:`CBT_ENT_WID_LSB] = `CBT_W32;
            entry[`CBT_ENT_CI] = ci_lat;
            entry[`CBT_ENT_ERR] = bus_error_seen;
            entry[`CBT_ENT_LAST] = beat_last;
        end
    end

    // ----------------------------------------
    // request capture and S0 pins
    // ----------------------------------------
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            address <= `CBT_RST_ADDR;
            space_code <= {`CBT_SPACE_W{1'b0}};
            read_not_write <= 1'b1;
            transfer_bytes <= `CBT_TB_LONG;
            cache_inhibit_out_n <= `CBT_RST_PIN_N;
            data_out <= `CBT_RST_DATA;
            r_first <= 1'b0;
            r_ci_out <= 1'b0;
            r_write <= 1'b0;
            r_burst <= 1'b0;
            r_table <= 1'b0;
            r_cache_en <= 1'b0;
            r_size <= `CBT_TB_LONG;
            r_off <= 2'h0;
        end
        else if (take)
        begin
            address <= req_addr;
            space_code <= req_space;
            read_not_write <= !req_write;
            transfer_bytes <= req_size;
            cache_inhibit_out_n <= !req_ci_out;
            data_out <= req_wdata;
            r_first <= req_first;
            r_ci_out <= req_ci_out;
            r_write <= req_write;
            r_burst <= burst_ok;
            r_table <= req_table;
            r_cache_en <= req_cache_en;
            r_size <= req_size;
            r_off <= req_addr[1:0];
        end
    end

    // ----------------------------------------
    // cycle sequencer
    // ----------------------------------------
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_IDLE;
            ph <= 1'b0;
            req_ready <= 1'b0;
            ext_cycle_start_n <= `CBT_RST_PIN_N;
            operand_cycle_start_n <= `CBT_RST_PIN_N;
            address_strobe_n <= `CBT_RST_PIN_N;
            data_strobe_n <= `CBT_RST_PIN_N;
            data_buffer_en_n <= `CBT_RST_PIN_N;
            cache_burst_req_n <= `CBT_RST_PIN_N;
            data_oe <= 1'b0;
            ack_seen <= 1'b0;
            bus_error_seen <= 1'b0;
            halt_seen <= 1'b0;
            retry_pend <= 1'b0;
            ci_lat <= 1'b0;
            cb_lat <= 1'b0;
            width_lat <= `CBT_WNONE;
            beat <= 2'h0;
        end
        else
        begin
            ph <= ~ph;
            req_ready <= 1'b0;
            if (launch)
            begin
                state <= ST_S0;
                ext_cycle_start_n <= 1'b0;
                operand_cycle_start_n <= take ? !req_first : !r_first;
                cache_burst_req_n <= take ? !burst_ok : !r_burst;
                data_buffer_en_n <= 1'b1;
                data_oe <= 1'b0;
                ack_seen <= 1'b0;
                bus_error_seen <= 1'b0;
                halt_seen <= 1'b0;
                retry_pend <= 1'b0;
                ci_lat <= 1'b0;
                cb_lat <= 1'b0;
                width_lat <= `CBT_WNONE;
                beat <= 2'h0;
            end
            else
            begin
                case (state)
                    ST_IDLE:
                    begin
                        req_ready <= !ph && room_next;
                    end
                    ST_S0:
                    begin
                        ext_cycle_start_n <= 1'b1;
                        operand_cycle_start_n <= 1'b1;
                        if (req_cancel)
                        begin
                            cache_burst_req_n <= 1'b1;
                            state <= ST_IDLE;
                        end
                        else
                        begin
                            address_strobe_n <= 1'b0;
                            data_strobe_n <= r_write;
                            data_buffer_en_n <= !r_write;
                            state <= ST_S1;
                        end
                    end
                    ST_S1, ST_W1:
                    begin
                        data_oe <= r_write;
                        if (!sync_terminate_n)
                        begin
                            cb_lat <= r_burst && !cache_burst_ack_n;
                            ci_lat <= ci_eff;
                            bus_error_seen <= !bus_error_n;
                            halt_seen <= !halt_n;
                            state <= ST_T2;
                        end
                        else
                            state <= ST_S2;
                        if (!r_write)
                            data_buffer_en_n <= 1'b0;
                    end
                    ST_S2:
                    begin
                        if (r_write)
                            data_strobe_n <= 1'b0;
                        // wait one bus clock per miss
                        if (ack_rec || !bus_error_n)
                        begin
                            ack_seen <= ack_rec;
                            width_lat <= ack_width;
                            bus_error_seen <= !bus_error_n;
                            halt_seen <= !halt_n;
                            state <= ST_S3;
                        end
                        else
                            state <= ST_W1;
                    end
                    ST_S3:
                    begin
                        ci_lat <= ci_eff;
                        state <= ST_S4;
                    end
                    ST_S4:
                    begin
                        // data latched via push this edge
                        address_strobe_n <= 1'b1;
                        data_strobe_n <= 1'b1;
                        data_buffer_en_n <= 1'b1;
                        cache_burst_req_n <= 1'b1;
                        bus_error_seen <= bus_error_now;
                        halt_seen <= halt_seen || !halt_n;
                        retry_pend <= retry_now;
                        req_ready <= !retry_now && room_next;
                        state <= ST_S5;
                    end
                    ST_T2:
                    begin
                        beat <= beat + 2'h1;
                        // next beat at earliest one bus clock on
                        if (!beat_last)
                            state <= ST_B1;
                        else
                        begin
                            address_strobe_n <= 1'b1;
                            data_strobe_n <= 1'b1;
                            data_buffer_en_n <= 1'b1;
                            cache_burst_req_n <= 1'b1;
                            retry_pend <= bus_error_seen && halt_seen;
                            req_ready <= !(bus_error_seen && halt_seen) && room_next;
                            state <= ST_END;
                        end
                    end
                    ST_B1:
                    begin
                        // each beat ends on terminate or bus error
                        // waits stay whole bus clocks so S0 keeps ph low
                        if (ph && (!sync_terminate_n || !bus_error_n))
                        begin
                            bus_error_seen <= !bus_error_n;
                            halt_seen <= !halt_n;
                            state <= ST_T2;
                        end
                    end
                    ST_S5, ST_END:
                    begin
                        data_oe <= 1'b0;
                        state <= retry_pend ? ST_HALT : ST_IDLE;
                    end
                    ST_HALT:
                    begin
                        state <= ST_HALT;
                    end
                    default:
                    begin
                        state <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule // cbt_bus_ctrl
`default_nettype wire

/* hdl/cbt_fifo.v */
`timescale 1ns/1ns
`default_nettype none
`include "cbt_defs.vh"

module cbt_fifo
#(
    parameter WIDTH = `CBT_ENT_W,
    parameter DEPTH = `CBT_FIFO_DEPTH,
    parameter AW = 2
)
(
    // clock and reset
    input wire clk,
    input wire rst_n,
    // fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data,
    // occupancy
    output reg [AW:0] level
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wptr;
    reg [AW-1:0] rptr;
    wire push;
    wire pop;

    assign in_ready = (level != DEPTH[AW:0]);
    assign out_valid = (level != {(AW+1){1'b0}});
    assign out_data = mem[rptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // ----------------------------------------
    // pointers and storage
    // ----------------------------------------
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wptr <= {AW{1'b0}};
            rptr <= {AW{1'b0}};
            level <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wptr <= (wptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr + 1'b1;
            if (pop)
                rptr <= (rptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr + 1'b1;
            if (push && !pop)
                level <= level + 1'b1;
            else if (pop && !push)
                level <= level - 1'b1;
        end
    end

    // storage holds no control state, so it needs no reset
    always @(posedge clk)
    begin
        if (push)
            mem[wptr] <= in_data;
    end

endmodule // cbt_fifo
`default_nettype wire

/* pkg/cbt_defs.vh */
`ifndef CBT_DEFS_VH
`define CBT_DEFS_VH

// ----------------------------------------
// widths and sizes
// ----------------------------------------
`define CBT_ADDR_W 32
`define CBT_DATA_W 32
`define CBT_SPACE_W 3
`define CBT_FIFO_DEPTH 4

// ----------------------------------------
// timing
// ----------------------------------------
// one clk cycle models one bus state, i.e. half a bus clock
`define CBT_CLK_NS 20
`define CBT_STATES_PER_BUS_CLK 2
`define CBT_ASYNC_MIN_BUS_CLKS 3
`define CBT_SYNC_MIN_BUS_CLKS 2
`define CBT_BURST_BEATS 4

// ----------------------------------------
// transfer_bytes encodings
// ----------------------------------------
`define CBT_TB_LONG 2'h0
`define CBT_TB_BYTE 2'h1
`define CBT_TB_WORD 2'h2
`define CBT_TB_THREE 2'h3

// ----------------------------------------
// port width codes
// ----------------------------------------
`define CBT_W32 2'h0
`define CBT_W8 2'h1
`define CBT_W16 2'h2
`define CBT_WNONE 2'h3

// ----------------------------------------
// completion entry layout
// ----------------------------------------
`define CBT_ENT_W 37
`define CBT_ENT_DATA_LSB 0
`define CBT_ENT_DATA_MSB 31
`define CBT_ENT_WID_LSB 32
`define CBT_ENT_WID_MSB 33
`define CBT_ENT_CI 34
`define CBT_ENT_ERR 35
`define CBT_ENT_LAST 36

// ----------------------------------------
// reset values
// ----------------------------------------
`define CBT_RST_PIN_N 1'b1
`define CBT_RST_ADDR 32'h00000000
`define CBT_RST_DATA 32'h00000000

`endif

/* sim/cbt_bus_ctrl_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module cbt_bus_ctrl_assertions
(
    // watched ports
    input wire logic clk, rst_n, req_write, req_first, read_not_write, data_oe, done_valid, done_err,
    input wire logic ext_cycle_start_n, operand_cycle_start_n, address_strobe_n, data_strobe_n,
    input wire logic data_buffer_en_n, sync_terminate_n, bus_error_n,
    input wire logic [31:0] req_addr, address,
    input wire logic [2:0] req_space, space_code,
    input wire logic [1:0] done_width, req_size, transfer_bytes
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    start_pulse_a: assert property ($fell(ext_cycle_start_n) |=> ext_cycle_start_n)
        else $error("start strobe too long");
    start_fields_a: assert property ($fell(ext_cycle_start_n) |-> address == $past(req_addr)
        && read_not_write == !$past(req_write) && operand_cycle_start_n == !$past(req_first)
        && space_code == $past(req_space) && transfer_bytes == $past(req_size)) else $error("bad S0");
    strobe_start_a: assert property ($fell(address_strobe_n) |-> !$past(ext_cycle_start_n) && ext_cycle_start_n
        && operand_cycle_start_n && (!data_strobe_n || !read_not_write)) else $error("bad S1");
    buffer_on_a: assert property ($fell(address_strobe_n) && read_not_write |=> !data_buffer_en_n)
        else $error("buffers late");
    // error cycles excluded: they may end early
    ack_min_a: assert property ($fell(address_strobe_n) && sync_terminate_n ##1 bus_error_n |-> !address_strobe_n [*3])
        else $error("ack cycle short");
    sync_min_a: assert property ($fell(address_strobe_n) |=> !address_strobe_n)
        else $error("cycle too short");
    drive_write_a: assert property (data_oe |-> !read_not_write)
        else $error("drives on read");
    width_err_a: assert property (done_valid && done_width == 2'h3 |-> done_err)
        else $error("no port width yet no error");
endmodule // cbt_bus_ctrl_assertions
bind cbt_bus_ctrl cbt_bus_ctrl_assertions chk (.*);
`default_nettype wire

/* sim/cbt_slave_model.sv */
`timescale 1ns/1ns
`default_nettype none
module cbt_slave_model
(
    // bus from the master, and the sync, bus error, burst ack and ci settings
    input wire logic clk, ext_cycle_start_n, address_strobe_n, sync, bus_error, cache_burst_ack, ci,
    input wire logic [31:0] address,
    // answer settings
    input wire logic [1:0] ack_code,
    input wire logic [3:0] wt,
    // answers
    output logic [31:0] data_in,
    output logic [1:0] data_size_ack_n,
    output logic sync_terminate_n, bus_error_n, halt_n, autovector_n, cache_inhibit_in_n, cache_burst_ack_n
);
    // settings latched at cycle start so the bench may change them early
    logic [9:0] cf = 10'h0;
    logic [3:0] cnt = 4'h0;
    wire logic [9:0] cur = ext_cycle_start_n ? cf : {ack_code, wt, sync, bus_error, cache_burst_ack, ci};
    wire logic live = !ext_cycle_start_n || !address_strobe_n;
    initial
    begin
        {data_in, data_size_ack_n} = 34'h3;
        {sync_terminate_n, bus_error_n, halt_n, autovector_n, cache_inhibit_in_n, cache_burst_ack_n} = 6'h3F;
    end
    always @(posedge clk)
    begin
        cf <= cur;
        cnt <= address_strobe_n ? 4'h0 : cnt + 4'h1;
        // width ack after waits, dropped with the strobe
        data_size_ack_n <= (!address_strobe_n && cnt >= cur[7:4]) ? cur[9:8] : 2'h3;
        // sync and burst ack decoded from cycle start, bus error only with the strobe, whatever the ack code
        sync_terminate_n <= !(cur[3] && live);
        bus_error_n <= !(cur[2] && !address_strobe_n);
        cache_burst_ack_n <= !(cur[1] && live);
        cache_inhibit_in_n <= !cur[0];
        // released lanes show the inverse, not stale data
        data_in <= address_strobe_n ? ~data_in : {address[31:2], 2'h0} ^ 32'h5A5A0F0F;
    end
endmodule // cbt_slave_model
`default_nettype wire

/* sim/test_cbt_bus_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
module test_cbt_bus_ctrl;
    logic clk, rst_n, req_valid, req_write, req_first, req_burst, req_cancel, done_ready, sync, bus_error, cache_burst_ack, ci;
    logic req_ci_out, req_table, req_cache_en, req_ready, done_valid, done_ci, done_err, done_last, data_oe;
    logic read_not_write, cache_inhibit_out_n, ext_cycle_start_n, operand_cycle_start_n, address_strobe_n;
    logic data_strobe_n, data_buffer_en_n, cache_burst_req_n, sync_terminate_n, bus_error_n, halt_n;
    logic autovector_n, cache_inhibit_in_n, cache_burst_ack_n;
    logic [31:0] req_addr, req_wdata, done_data, address, data_out, data_in;
    logic [2:0] req_space, space_code;
    logic [1:0] req_size, ack_code, done_width, transfer_bytes, data_size_ack_n;
    logic [3:0] wt;
    logic [36:0] q[$];
    integer mismatches = 0, total_checks = 0, seed = 32'h7a30044d, i, n;
    cbt_bus_ctrl uut (.*);
    cbt_slave_model slave (.*);
    initial
    begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    task check(input logic [31:0] got, exp);
    begin
        total_checks = total_checks + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task end_sim;
    begin
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    function automatic logic [31:0] exp_data(input logic [31:0] d, input logic [1:0] w, off, sz);
        int n;
    begin
        // bytes wanted, cut at the end of the long word
        n = (sz == 2'h0) ? 4 : sz;
        n = (n > 4 - off) ? 4 - off : n;
        if (w == 2'h1)
            exp_data = d >> 24;
        else if (w == 2'h2)
            exp_data = d >> 16;
        else
            exp_data = (d >> (8 * (4 - off - n))) & ~(32'hFFFFFFFF << (8 * n));
    end
    endfunction
    task cyc(input logic wr, bu, ca, sy, be, cb, input logic [1:0] ak);
        logic [31:0] a, d;
        logic [1:0] w, s;
        logic c;
    begin
        a = $random(seed);
        s = $random(seed);
        c = $random(seed) % 2 && !be;
        {req_valid, req_addr, req_write, req_burst, req_size} <= {1'h1, a, wr, bu, s};
        {req_first, req_space, req_wdata} <= {$random(seed), $random(seed)};
        {ack_code, sync, bus_error, cache_burst_ack, ci} <= {ak, sy, be, cb, c};
        wt <= {1'h0, 2'($random(seed)), 1'h0};
        n = 0;
        @(posedge clk);
        while (req_ready !== 1'h1 && n < 200)
        begin
            n = n + 1;
            @(posedge clk);
        end
        check(n < 200, 1'h1);
        req_valid <= 1'h0;
        req_cancel <= ca;
        @(posedge clk);
        req_cancel <= 1'h0;
        w = be ? 2'h3 : sy ? 2'h0 : {ak[0], ak[1]};
        d = wr ? 32'h0 : exp_data({a[31:2], 2'h0} ^ 32'h5A5A0F0F, w, a[1:0], s);
        if (!ca)
        begin
            repeat ((bu && sy && cb) ? 3 : 0)
                q.push_back({d, w, be, c && !wr, 1'h0});
            q.push_back({d, w, be, c && !wr, 1'h1});
        end
    end
    endtask
    task drain;
        logic [36:0] x;
    begin
        while (q.size() > 0)
        begin
            x = q.pop_front();
            n = 0;
            @(posedge clk);
            while (done_valid !== 1'h1 && n < 200)
            begin
                n = n + 1;
                @(posedge clk);
            end
            check(n < 200, 1'h1);
            if (!x[2])
                check(done_data, x[36:5]);
            check({done_width, done_err, done_ci, done_last}, x[4:0]);
            done_ready <= 1'h1;
            @(posedge clk);
            done_ready <= 1'h0;
        end
        repeat (10) @(posedge clk);
        check(done_valid, 1'h0);
    end
    endtask
    initial
    begin
        {rst_n, req_valid, req_write, req_first, req_burst, req_cancel, done_ready, sync, bus_error, cache_burst_ack, ci} = 11'h0;
        {req_ci_out, req_table, req_cache_en} = 3'h1;
        {req_addr, req_wdata, req_space, req_size, ack_code, wt} = 75'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        for (i = 0; i < 4; i = i + 1)
            cyc(0, 0, 0, 0, 0, 0, 2'(i % 3));
        // full completion queue must hold off the next request
        req_valid <= 1'h1;
        n = 0;
        repeat (20)
        begin
            @(posedge clk);
            n = n + (req_ready === 1'h1);
        end
        req_valid <= 1'h0;
        check(n, 0);
        drain;
        cyc(0, 0, 0, 1, 0, 0, 2'h3);
        cyc(0, 0, 0, 1, 0, 1, 2'h3);
        drain;
        cyc(0, 1, 0, 1, 0, 1, 2'h3);
        drain;
        cyc(0, 1, 0, 0, 0, 1, 2'h0);
        cyc(0, 0, 0, 0, 1, 0, 2'h3);
        cyc(0, 0, 1, 1, 0, 0, 2'h3);
        cyc(1, 0, 0, 0, 0, 0, 2'h0);
        drain;
        end_sim;
    end
    initial
    begin
        #100000;
        mismatches = mismatches + 1;
        end_sim;
    end
endmodule // test_cbt_bus_ctrl
`default_nettype wire
